// file: hw/fpmc_pkg.sv
// Package for the front panel mode control block
package fpmc_pkg;
    typedef enum logic [0:0] {FPMC_MODE_GAIN = 1'b0, FPMC_MODE_VOL = 1'b1} fpmc_mode_t;
    // Output selection in cycle order; one bit flips per step except speaker back to first
    typedef enum logic [1:0] {FPMC_OUT_PHONES_FIRST = 2'h0, FPMC_OUT_PHONES_SECOND = 2'h1, FPMC_OUT_SPK = 2'h3} fpmc_out_t;
    typedef enum logic [1:0] {FPMC_LAMP_OFF = 2'h0, FPMC_LAMP_DIM = 2'h1, FPMC_LAMP_BRIGHT = 2'h2} fpmc_lamp_t;
    localparam int NUM_CH = 4;
    localparam int NUM_OPT = 6;
    localparam int GAIN_W = 8;
    localparam int VOL_W = 8;
    // Option button positions
    localparam int OPT_SRC = 0;
    localparam int OPT_PAIR = 5;
    localparam int OPT_MUTE = 5;
    localparam logic [1:0] RST_CH = 2'h0;
    localparam logic [GAIN_W-1:0] RST_GAIN = 8'h00;
    localparam logic [VOL_W-1:0] RST_VOL = 8'h00;
    localparam logic [NUM_OPT-1:0] RST_OPTS = 6'h00;
    localparam logic [NUM_OPT-1:0] RST_OUT_OPTS = 6'h00;
endpackage

// file: hw/fpmc_top.sv
// Front panel mode, channel, output and lamp control
`timescale 1ns/1ns
`default_nettype none
module fpmc_top
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic GAIN_MODE_BTN,
    input wire logic VOL_MODE_BTN,
    input wire logic [5:0] OPTION_BTN,
    input wire logic KNOB_UP,
    input wire logic KNOB_DOWN,
    input wire logic [1:0] INSTRUMENT_PLUG,
    output logic MODE_IS_VOL,
    output logic [3:0] CHANNEL_LAMP,
    output logic [1:0] SELECTED_CHANNEL,
    output logic [2:0] SOURCE_SEL_IN0,
    output logic [2:0] SOURCE_SEL_IN1,
    output logic [2:0] SOURCE_SEL_IN2,
    output logic [2:0] SOURCE_SEL_IN3,
    output logic [2:0] SOURCE_LAMP,
    output logic [31:0] GAIN_ALL,
    output logic [7:0] VOL_PHONES_FIRST,
    output logic [7:0] VOL_PHONES_SECOND,
    output logic [7:0] VOL_SPK,
    output logic [2:0] OUTPUT_LAMP,
    output logic SPK_LAMP_RED,
    output logic SPK_MUTED,
    output logic RING_RED,
    output logic [7:0] RING_LEVEL,
    output logic [11:0] UPPER_LAMP,
    output logic [11:0] LOWER_LAMP
);
    // ************************************************************
    // Input synchronisers and press edges
    // ************************************************************
    // Bit order: gain, vol, opt[5:0], up, down, plug[1:0]
    localparam int NIN = 12;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync1_reg;
    logic [NIN-1:0] sync2_reg;
    logic [NIN-1:0] last_reg;
    logic [NIN-1:0] rise;
    assign raw_in = {GAIN_MODE_BTN, VOL_MODE_BTN, OPTION_BTN, KNOB_UP, KNOB_DOWN, INSTRUMENT_PLUG};
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            last_reg <= '0;
        end
        else
        begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            last_reg <= sync2_reg;
        end
    end
    // Press events, debounce assumed outside the block
    assign rise = sync2_reg & ~last_reg;
    logic p_gain;
    logic p_vol;
    logic [5:0] p_opt;
    logic p_up;
    logic p_dn;
    logic [1:0] plug;
    assign p_gain = rise[11];
    assign p_vol = rise[10];
    assign p_opt = rise[9:4];
    // Simultaneous up and down cancel
    assign p_up = rise[3] & ~rise[2];
    assign p_dn = rise[2] & ~rise[3];
    assign plug = sync2_reg[1:0];

    // ************************************************************
    // Mode, channel and output selection
    // ************************************************************
    fpmc_pkg::fpmc_mode_t mode_reg;
    logic [1:0] ch_reg;
    fpmc_pkg::fpmc_out_t out_reg;
    logic gain_mode;
    assign gain_mode = (mode_reg == fpmc_pkg::FPMC_MODE_GAIN);

    function automatic fpmc_pkg::fpmc_out_t next_out(input fpmc_pkg::fpmc_out_t o);
        unique case (o)
            fpmc_pkg::FPMC_OUT_PHONES_FIRST: next_out = fpmc_pkg::FPMC_OUT_PHONES_SECOND;
            fpmc_pkg::FPMC_OUT_PHONES_SECOND: next_out = fpmc_pkg::FPMC_OUT_SPK;
            fpmc_pkg::FPMC_OUT_SPK: next_out = fpmc_pkg::FPMC_OUT_PHONES_FIRST;
            default: next_out = fpmc_pkg::FPMC_OUT_SPK;
        endcase
    endfunction

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            mode_reg <= fpmc_pkg::FPMC_MODE_GAIN;
            ch_reg <= fpmc_pkg::RST_CH;
            out_reg <= fpmc_pkg::FPMC_OUT_SPK;
        end
        else if (p_gain)
        begin
            // Gain button wins if both pressed together
            mode_reg <= fpmc_pkg::FPMC_MODE_GAIN;
            if (gain_mode)
                ch_reg <= ch_reg + 2'h1;
        end
        else if (p_vol)
        begin
            mode_reg <= fpmc_pkg::FPMC_MODE_VOL;
            if (!gain_mode)
                out_reg <= next_out(out_reg);
        end
    end

    // ************************************************************
    // Per channel options, source and gain
    // ************************************************************
    logic [5:0] opts_reg [fpmc_pkg::NUM_CH];
    logic [7:0] gain_reg [fpmc_pkg::NUM_CH];
    logic [3:0] touched;
    logic [1:0] partner;
    logic sel_paired;
    assign partner = ch_reg ^ 2'h1;
    assign sel_paired = opts_reg[ch_reg][fpmc_pkg::OPT_PAIR];
    // Pair press flips the partner too, so both sides of a join agree
    logic pair_reach;
    assign pair_reach = sel_paired || p_opt[fpmc_pkg::OPT_PAIR];

    genvar g;
    generate
        for (g = 0; g < fpmc_pkg::NUM_CH; g++)
        begin : g_ch
            // Channel follows the selection, and its pair partner when joined
            assign touched[g] = (ch_reg == 2'(g)) || (pair_reach && partner == 2'(g));
            always_ff @(posedge CLK)
            begin
                if (SYS_RST)
                begin
                    opts_reg[g] <= fpmc_pkg::RST_OPTS;
                    gain_reg[g] <= fpmc_pkg::RST_GAIN;
                end
                else if (gain_mode && touched[g])
                begin
                    opts_reg[g] <= opts_reg[g] ^ p_opt;
                    if (p_up && gain_reg[g] != 8'hFF)
                        gain_reg[g] <= gain_reg[g] + 8'h01;
                    else if (p_dn && gain_reg[g] != 8'h00)
                        gain_reg[g] <= gain_reg[g] - 8'h01;
                end
            end
        end
    endgenerate

    // One-hot source: {instrument, line, mic}
    function automatic logic [2:0] src_of(input logic [1:0] c, input logic line_sel, input logic [1:0] pl);
        logic inst;
        inst = (c < 2'h2) ? pl[c[0]] : 1'b0;
        if (inst)
            src_of = 3'h4;
        else if (line_sel)
            src_of = 3'h2;
        else
            src_of = 3'h1;
    endfunction

    // Instrument jack beats the stored mic or line choice
    logic [2:0] src_all [fpmc_pkg::NUM_CH];
    always_comb
    begin
        for (int i = 0; i < fpmc_pkg::NUM_CH; i++)
            src_all[i] = src_of(2'(i), opts_reg[i][fpmc_pkg::OPT_SRC], plug);
    end

    // ************************************************************
    // Output volumes and mute
    // ************************************************************
    logic [7:0] vol_reg [3];
    logic [5:0] out_opts_reg;
    logic [1:0] out_idx;
    assign out_idx = (out_reg == fpmc_pkg::FPMC_OUT_PHONES_FIRST) ? 2'h0 :
                     (out_reg == fpmc_pkg::FPMC_OUT_PHONES_SECOND) ? 2'h1 : 2'h2;
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            for (int i = 0; i < 3; i++)
                vol_reg[i] <= fpmc_pkg::RST_VOL;
        end
        else if (!gain_mode)
        begin
            if (p_up && vol_reg[out_idx] != 8'hFF)
                vol_reg[out_idx] <= vol_reg[out_idx] + 8'h01;
            else if (p_dn && vol_reg[out_idx] != 8'h00)
                vol_reg[out_idx] <= vol_reg[out_idx] - 8'h01;
        end
    end
    // Only mute is modelled among output options; others toggle freely
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            out_opts_reg <= fpmc_pkg::RST_OUT_OPTS;
        else if (!gain_mode)
        begin
            out_opts_reg[4:0] <= out_opts_reg[4:0] ^ p_opt[4:0];
            if (p_opt[fpmc_pkg::OPT_MUTE] && out_reg == fpmc_pkg::FPMC_OUT_SPK)
                out_opts_reg[fpmc_pkg::OPT_MUTE] <= ~out_opts_reg[fpmc_pkg::OPT_MUTE];
        end
    end

    // ************************************************************
    // Lamps and registered outputs
    // ************************************************************
    logic mute;
    assign mute = out_opts_reg[fpmc_pkg::OPT_MUTE];

    function automatic logic [11:0] lamp_row(input logic [5:0] o, input logic [5:0] avail);
        for (int i = 0; i < fpmc_pkg::NUM_OPT; i++)
            lamp_row[2*i +: 2] = !avail[i] ? fpmc_pkg::FPMC_LAMP_OFF :
                                 o[i] ? fpmc_pkg::FPMC_LAMP_BRIGHT : fpmc_pkg::FPMC_LAMP_DIM;
    endfunction

    // Mute only available with speaker selected
    logic [5:0] out_avail;
    assign out_avail = {out_reg == fpmc_pkg::FPMC_OUT_SPK, 5'h1F};

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            MODE_IS_VOL <= 1'b0;
            CHANNEL_LAMP <= 4'h1;
            SELECTED_CHANNEL <= 2'h0;
            SOURCE_LAMP <= 3'h1;
            OUTPUT_LAMP <= 3'h4;
            SPK_LAMP_RED <= 1'b0;
            SPK_MUTED <= 1'b0;
            RING_RED <= 1'b0;
            RING_LEVEL <= 8'h00;
            UPPER_LAMP <= 12'h555;
            LOWER_LAMP <= 12'h000;
        end
        else
        begin
            MODE_IS_VOL <= !gain_mode;
            CHANNEL_LAMP <= 4'h1 << ch_reg;
            SELECTED_CHANNEL <= ch_reg;
            SOURCE_LAMP <= src_all[ch_reg];
            OUTPUT_LAMP <= {out_reg == fpmc_pkg::FPMC_OUT_SPK, out_reg == fpmc_pkg::FPMC_OUT_PHONES_SECOND,
                            out_reg == fpmc_pkg::FPMC_OUT_PHONES_FIRST};
            SPK_LAMP_RED <= mute;
            SPK_MUTED <= mute;
            RING_RED <= mute && !gain_mode;
            RING_LEVEL <= gain_mode ? gain_reg[ch_reg] : vol_reg[out_idx];
            UPPER_LAMP <= gain_mode ? lamp_row(opts_reg[ch_reg], 6'h3F) : 12'h000;
            LOWER_LAMP <= gain_mode ? 12'h000 : lamp_row(out_opts_reg, out_avail);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            SOURCE_SEL_IN0 <= 3'h1;
            SOURCE_SEL_IN1 <= 3'h1;
            SOURCE_SEL_IN2 <= 3'h1;
            SOURCE_SEL_IN3 <= 3'h1;
            GAIN_ALL <= 32'h0;
            VOL_PHONES_FIRST <= 8'h00;
            VOL_PHONES_SECOND <= 8'h00;
            VOL_SPK <= 8'h00;
        end
        else
        begin
            SOURCE_SEL_IN0 <= src_all[0];
            SOURCE_SEL_IN1 <= src_all[1];
            SOURCE_SEL_IN2 <= src_all[2];
            SOURCE_SEL_IN3 <= src_all[3];
            GAIN_ALL <= {gain_reg[3], gain_reg[2], gain_reg[1], gain_reg[0]};
            VOL_PHONES_FIRST <= vol_reg[0];
            VOL_PHONES_SECOND <= vol_reg[1];
            VOL_SPK <= vol_reg[2];
        end
    end
endmodule
`default_nettype wire

// file: tb/fpmc_chk.sv
// Assertion checker for the panel controller
`timescale 1ns/1ns
`default_nettype none
module fpmc_chk
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [1:0] INSTRUMENT_PLUG,
    input wire logic MODE_IS_VOL,
    input wire logic [3:0] CHANNEL_LAMP,
    input wire logic [2:0] SOURCE_SEL_IN0,
    input wire logic [31:0] GAIN_ALL,
    input wire logic [7:0] VOL_SPK,
    input wire logic [2:0] OUTPUT_LAMP,
    input wire logic SPK_LAMP_RED,
    input wire logic SPK_MUTED,
    input wire logic RING_RED,
    input wire logic [11:0] UPPER_LAMP,
    input wire logic [11:0] LOWER_LAMP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_reset_state: assert property ($past(SYS_RST) |-> !MODE_IS_VOL && CHANNEL_LAMP == 4'h1 && !SPK_MUTED)
        else $error("bad state after reset");
    a_chan_onehot: assert property ($onehot(CHANNEL_LAMP))
        else $error("channel lamp not one-hot");
    a_src_onehot: assert property ($onehot(SOURCE_SEL_IN0))
        else $error("source not one-hot");
    a_plug_wins: assert property (INSTRUMENT_PLUG[0] [*8] |-> SOURCE_SEL_IN0 == 3'h4)
        else $error("plug did not override");
    a_ring_red: assert property ((SPK_MUTED && MODE_IS_VOL) [*3] |-> RING_RED && SPK_LAMP_RED)
        else $error("ring not red");
    a_ring_clear: assert property (!SPK_MUTED [*3] |-> !RING_RED && !SPK_LAMP_RED)
        else $error("red without mute");
    a_mute_spk: assert property ($changed(SPK_MUTED) |-> MODE_IS_VOL && OUTPUT_LAMP == 3'h4)
        else $error("mute changed off speaker");
    a_vol_frozen: assert property (!MODE_IS_VOL [*2] |-> $stable(VOL_SPK))
        else $error("volume moved in gain mode");
    a_gain_frozen: assert property (MODE_IS_VOL [*2] |-> $stable(GAIN_ALL))
        else $error("gain moved in volume mode");
    a_upper_dark: assert property (MODE_IS_VOL [*2] |-> UPPER_LAMP == 12'h000)
        else $error("upper row lit");
    a_lower_dark: assert property (!MODE_IS_VOL [*2] |-> LOWER_LAMP == 12'h000)
        else $error("lower row lit");
    c_muted: cover property (SPK_MUTED && MODE_IS_VOL);
    c_plug: cover property (SOURCE_SEL_IN0 == 3'h4);
    c_vol: cover property ($rose(MODE_IS_VOL));
endmodule
bind fpmc_top fpmc_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .INSTRUMENT_PLUG(INSTRUMENT_PLUG),
    .MODE_IS_VOL(MODE_IS_VOL), .CHANNEL_LAMP(CHANNEL_LAMP), .SOURCE_SEL_IN0(SOURCE_SEL_IN0), .GAIN_ALL(GAIN_ALL),
    .VOL_SPK(VOL_SPK), .OUTPUT_LAMP(OUTPUT_LAMP), .SPK_LAMP_RED(SPK_LAMP_RED), .SPK_MUTED(SPK_MUTED),
    .RING_RED(RING_RED), .UPPER_LAMP(UPPER_LAMP), .LOWER_LAMP(LOWER_LAMP));
`default_nettype wire

// file: tb/fpmc_op.sv
// Operator model pressing panel buttons and turning the knob
`timescale 1ns/1ns
`default_nettype none
module fpmc_op
(
    input wire logic clk,
    output logic [9:0] btn
);
    initial btn = 10'h000;
    // Held three cycles so the synchronisers see it; long gap before next press
    task automatic hit(input int i);
        @(posedge clk);
        #1 btn = btn | (10'h001 << i);
        repeat (3) @(posedge clk);
        #1 btn = btn & ~(10'h001 << i);
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the panel controller
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic CLK = 1'b0;
    logic SYS_RST;
    logic [1:0] INSTRUMENT_PLUG;
    logic [9:0] btn;
    logic MODE_IS_VOL, SPK_LAMP_RED, SPK_MUTED, RING_RED;
    logic [1:0] SELECTED_CHANNEL;
    logic [2:0] SOURCE_SEL_IN0, SOURCE_SEL_IN1, SOURCE_SEL_IN2, SOURCE_SEL_IN3, SOURCE_LAMP, OUTPUT_LAMP;
    logic [3:0] CHANNEL_LAMP;
    logic [7:0] VOL_PHONES_FIRST, VOL_PHONES_SECOND, VOL_SPK, RING_LEVEL;
    logic [11:0] UPPER_LAMP, LOWER_LAMP;
    logic [31:0] GAIN_ALL;
    int mismatches = 0;
    int n_checks = 0;
    always #4 CLK = ~CLK;
    fpmc_op op (.clk(CLK), .btn(btn));
    fpmc_top DUT (.CLK(CLK), .SYS_RST(SYS_RST), .GAIN_MODE_BTN(btn[0]), .VOL_MODE_BTN(btn[1]),
        .OPTION_BTN(btn[7:2]), .KNOB_UP(btn[8]), .KNOB_DOWN(btn[9]), .INSTRUMENT_PLUG(INSTRUMENT_PLUG),
        .MODE_IS_VOL(MODE_IS_VOL), .CHANNEL_LAMP(CHANNEL_LAMP), .SELECTED_CHANNEL(SELECTED_CHANNEL),
        .SOURCE_SEL_IN0(SOURCE_SEL_IN0), .SOURCE_SEL_IN1(SOURCE_SEL_IN1), .SOURCE_SEL_IN2(SOURCE_SEL_IN2),
        .SOURCE_SEL_IN3(SOURCE_SEL_IN3), .SOURCE_LAMP(SOURCE_LAMP), .GAIN_ALL(GAIN_ALL),
        .VOL_PHONES_FIRST(VOL_PHONES_FIRST), .VOL_PHONES_SECOND(VOL_PHONES_SECOND), .VOL_SPK(VOL_SPK),
        .OUTPUT_LAMP(OUTPUT_LAMP), .SPK_LAMP_RED(SPK_LAMP_RED), .SPK_MUTED(SPK_MUTED), .RING_RED(RING_RED),
        .RING_LEVEL(RING_LEVEL), .UPPER_LAMP(UPPER_LAMP), .LOWER_LAMP(LOWER_LAMP));
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (!ok)
        begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Walks all four channels, wrap included
    task automatic t_chan();
        for (int i = 1; i <= 4; i++)
        begin
            op.hit(0);
            chk(SELECTED_CHANNEL === 2'(i % 4), "channel index");
            chk(CHANNEL_LAMP === 4'h1 << (i % 4), "channel lamp");
        end
        $display("t_chan done");
    endtask
    task automatic t_gain();
        op.hit(9);
        chk(GAIN_ALL === 32'h0000_0000, "gain floor");
        op.hit(0);
        op.hit(8);
        op.hit(8);
        chk(GAIN_ALL === 32'h0000_0200, "gain of channel two");
        chk(RING_LEVEL === 8'h02, "ring level");
        $display("t_gain done");
    endtask
    task automatic t_src();
        op.hit(2);
        chk(SOURCE_SEL_IN1 === 3'h2 && SOURCE_LAMP === 3'h2, "line chosen");
        repeat (3) op.hit(0);
        chk(SOURCE_LAMP === 3'h1 && SOURCE_SEL_IN0 === 3'h1, "channel one mic");
        op.hit(0);
        chk(SOURCE_LAMP === 3'h2, "channel two restored");
        $display("t_src done");
    endtask
    // Pairing left on: later gain values rely on both channels moving
    task automatic t_pair();
        chk(UPPER_LAMP[11:10] === 2'h1, "pair lamp dim");
        op.hit(7);
        chk(UPPER_LAMP[11:10] === 2'h2, "pair lamp bright");
        op.hit(8);
        chk(GAIN_ALL === 32'h0000_0301, "paired gain");
        $display("t_pair done");
    endtask
    // Both jacks plugged; channels three and four have none and keep the mic
    task automatic t_plug();
        INSTRUMENT_PLUG = 2'h3;
        repeat (10) @(posedge CLK);
        #1;
        chk(SOURCE_SEL_IN0 === 3'h4 && SOURCE_SEL_IN1 === 3'h4 && SOURCE_LAMP === 3'h4, "instrument routed");
        chk(SOURCE_SEL_IN2 === 3'h1 && SOURCE_SEL_IN3 === 3'h1, "no jack on three and four");
        INSTRUMENT_PLUG = 2'h0;
        repeat (10) @(posedge CLK);
        #1;
        chk(SOURCE_SEL_IN0 === 3'h1 && SOURCE_SEL_IN1 === 3'h2, "mic and line back");
        $display("t_plug done");
    endtask
    task automatic t_vol();
        op.hit(1);
        chk(MODE_IS_VOL === 1'b1 && OUTPUT_LAMP === 3'h4, "volume mode");
        chk(UPPER_LAMP === 12'h000, "upper dark");
        op.hit(8);
        op.hit(2);
        chk(VOL_SPK === 8'h01 && GAIN_ALL === 32'h0000_0301, "volume only");
        chk(SOURCE_SEL_IN1 === 3'h2, "source untouched");
        chk(LOWER_LAMP === 12'h556, "output options shown");
        op.hit(1);
        chk(OUTPUT_LAMP === 3'h1, "first headphone");
        chk(LOWER_LAMP === 12'h156, "mute unavailable");
        op.hit(8);
        chk(VOL_PHONES_FIRST === 8'h01 && VOL_SPK === 8'h01 && RING_LEVEL === 8'h01, "phones one");
        op.hit(7);
        chk(SPK_MUTED === 1'b0, "mute ignored");
        op.hit(1);
        chk(OUTPUT_LAMP === 3'h2, "second headphone");
        op.hit(8);
        op.hit(8);
        chk(VOL_PHONES_SECOND === 8'h02 && VOL_PHONES_FIRST === 8'h01, "phones two");
        op.hit(1);
        chk(OUTPUT_LAMP === 3'h4, "speaker again");
        op.hit(7);
        chk(SPK_MUTED === 1'b1 && SPK_LAMP_RED === 1'b1 && RING_RED === 1'b1, "muted red");
        chk(LOWER_LAMP === 12'h956, "mute lamp bright");
        op.hit(0);
        chk(MODE_IS_VOL === 1'b0 && RING_RED === 1'b0 && LOWER_LAMP === 12'h000, "gain mode");
        chk(SPK_LAMP_RED === 1'b1 && RING_LEVEL === 8'h03, "mute kept in gain mode");
        $display("t_vol done");
    endtask
    initial
    begin
        SYS_RST = 1'b1;
        INSTRUMENT_PLUG = 2'h0;
        repeat (8) @(posedge CLK);
        #1 SYS_RST = 1'b0;
        chk(CHANNEL_LAMP === 4'h1 && OUTPUT_LAMP === 3'h4 && UPPER_LAMP === 12'h555, "reset lamps");
        t_chan();
        t_gain();
        t_src();
        t_pair();
        t_plug();
        t_vol();
        results();
    end
    initial
    begin
        repeat (3000) @(posedge CLK);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
